// [include/csp_pkg.sv]
// ==========================================================
// clocked serial port constants and types
package csp_pkg;
    // register map (byte offsets on the plain register port)
    localparam logic [15:0] CSP_ADDR_MODE = 16'hff80; // serial_mode_control
    localparam logic [15:0] CSP_ADDR_SHIFT = 16'hff81; // shift_register data port
    localparam logic [15:0] CSP_ADDR_BAUD = 16'hff82; // baud divisor for clock select 01
    // reset values
    localparam logic [7:0] CSP_MODE_RESET = 8'h00;
    localparam logic [7:0] CSP_BAUD_RESET = 8'h00;
    // field positions in serial_mode_control
    localparam int CSP_BIT_TXE = 7;
    localparam int CSP_BIT_RXE = 6;
    localparam int CSP_BIT_WUP = 5;
    localparam int CSP_BIT_PSEL = 4;
    localparam int CSP_POS_MODE = 2;
    localparam int CSP_POS_CLS = 0;
    // clock select codes
    localparam logic [1:0] CSP_CLS_EXT = 2'h0;
    localparam logic [1:0] CSP_CLS_BAUD = 2'h1;
    localparam logic [1:0] CSP_CLS_DIV32 = 2'h2;
    localparam logic [1:0] CSP_CLS_DIV8 = 2'h3;
    // mode codes
    localparam logic [1:0] CSP_MODE_MSB = 2'h0;
    localparam logic [1:0] CSP_MODE_LSB = 2'h1;
    localparam logic [1:0] CSP_MODE_BUS = 2'h2;
    // system clock divide ratios per full serial clock period
    localparam int CSP_DIV_SLOW = 32;
    localparam int CSP_DIV_FAST = 8;
    // bits per frame
    localparam int CSP_FRAME_BITS = 8;
    // decoded view of serial_mode_control
    typedef struct packed {
        logic tx_en;      // transmit_enable_bit
        logic rx_en;      // receive_enable_bit
        logic wakeup;     // wakeup_bit
        logic pin_sel;    // data_pin_select
        logic [1:0] mode; // mode_select_high/low
        logic [1:0] cls;  // clock_select_high/low
    } csp_mode_t;
    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csp_req_t;
endpackage : csp_pkg

// [src/csp_port.sv]
`timescale 1ns/1ps
module csp_port
    import csp_pkg::*;
#(
    parameter int BAUD_W = 8 // not used; the baud divisor baud_q is fixed at 8 bits
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire csp_req_t req,            // register port request
    output logic [7:0] rdata,           // read data, cycle after read
    input wire logic sck_in,            // serial clock pin level
    output logic sck_out,               // serial clock drive level
    output logic sck_oe,                // serial clock output enable
    input wire logic pin_a_in,          // bus_data_pin_a level (serial out in 3-wire)
    output logic pin_a_out,
    output logic pin_a_oe,
    input wire logic pin_b_in,          // bus_data_pin_b level (serial in in 3-wire)
    output logic pin_b_out,
    output logic pin_b_oe,
    output logic transfer_done_irq      // one-cycle request pulse
);
    // ==========================================================
    // register state
    csp_mode_t mode_q;          // serial_mode_control
    logic [7:0] baud_q;         // baud generator divisor
    logic [7:0] shreg;          // shift_register
    logic [3:0] bit_cnt;        // rising edges seen in frame
    logic busy;                 // frame in progress
    logic sck_lvl;              // generated clock level
    logic sck_prev;             // last sampled external clock
    logic [7:0] div_cnt;        // internal half-period counter
    typedef enum logic [1:0] {CSP_IDLE, CSP_RUN} csp_state_t;
    csp_state_t state;

    // decoded strobes
    logic wr_mode, wr_shift, wr_baud, rd_shift;
    assign wr_mode = req.wr && (req.addr == CSP_ADDR_MODE);
    assign wr_shift = req.wr && (req.addr == CSP_ADDR_SHIFT);
    assign wr_baud = req.wr && (req.addr == CSP_ADDR_BAUD);
    assign rd_shift = req.rd && (req.addr == CSP_ADDR_SHIFT);

    // mode decode: the prohibited code 11 falls back to msb-first three-wire
    logic bus_mode, lsb_first, internal_clk;
    assign bus_mode = (mode_q.mode == CSP_MODE_BUS);
    assign lsb_first = (mode_q.mode == CSP_MODE_LSB);
    assign internal_clk = (mode_q.cls != CSP_CLS_EXT);

    // ==========================================================
    // start conditions
    logic start;
    logic new_rx_en, new_tx_en;
    assign new_rx_en = req.wdata[CSP_BIT_RXE];
    assign new_tx_en = req.wdata[CSP_BIT_TXE];
    always_comb begin
        start = 1'b0;
        if (wr_shift && mode_q.tx_en) begin
            start = 1'b1;
        end else if (wr_mode && new_rx_en && !mode_q.rx_en && !new_tx_en) begin
            start = 1'b1;
        end else if (rd_shift && mode_q.rx_en && !mode_q.tx_en) begin
            start = 1'b1;
        end
    end

    // ==========================================================
    // mode and baud registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= csp_mode_t'(CSP_MODE_RESET);
        end else if (wr_mode) begin
            mode_q <= csp_mode_t'(req.wdata);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            baud_q <= CSP_BAUD_RESET;
        end else if (wr_baud) begin
            baud_q <= req.wdata;
        end
    end

    // ==========================================================
    // internal clock divider: half-period count per select
    logic [7:0] half_len;
    always_comb begin
        case (mode_q.cls)
            CSP_CLS_BAUD: half_len = baud_q; // divider output then halved
            CSP_CLS_DIV32: half_len = 8'((CSP_DIV_SLOW / 2) - 1);
            CSP_CLS_DIV8: half_len = 8'((CSP_DIV_FAST / 2) - 1);
            default: half_len = 8'h00;
        endcase
    end

    // one tick per half period of the generated clock, only inside a frame
    logic half_tick;
    assign half_tick = busy && internal_clk && (div_cnt == half_len);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= 8'h00;
        end else if (!busy || half_tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ==========================================================
    // serial clock edges, internal or external
    logic fall_ev, rise_ev;
    always_comb begin
        if (internal_clk) begin
            fall_ev = half_tick && sck_lvl;
            rise_ev = half_tick && !sck_lvl;
        end else begin
            // no frame, no shift
            fall_ev = busy && sck_prev && !sck_in;
            rise_ev = busy && !sck_prev && sck_in;
        end
    end

    // pin level one cycle back; resets to idle high so no false edge follows
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_lvl <= 1'b1;
        end else if (!busy) begin
            sck_lvl <= 1'b1;
        end else if (half_tick) begin
            sck_lvl <= ~sck_lvl;
        end
    end

    // ==========================================================
    // frame state and bit counter
    logic last_rise;
    assign last_rise = rise_ev && (bit_cnt == 4'(CSP_FRAME_BITS - 1));
    logic both_off;
    assign both_off = !mode_q.tx_en && !mode_q.rx_en;

    // frame state: idle until a start, back on the eighth rise or an abort
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= CSP_IDLE;
        end else begin
            case (state)
                CSP_IDLE: if (start) state <= CSP_RUN;
                CSP_RUN: if (last_rise || both_off) state <= CSP_IDLE;
                default: state <= CSP_IDLE;
            endcase
        end
    end
    assign busy = (state == CSP_RUN);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 4'h0;
        end else if (start || both_off || last_rise) begin
            bit_cnt <= 4'h0;
        end else if (rise_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // ==========================================================
    // shift register
    logic rx_bit;
    always_comb begin
        if (!mode_q.rx_en) begin
            rx_bit = 1'b0;
        end else if (bus_mode) begin
            rx_bit = mode_q.pin_sel ? pin_b_in : pin_a_in;
        end else begin
            rx_bit = pin_b_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shreg <= 8'h00;
        end else if (wr_shift) begin
            shreg <= req.wdata;
        end else if (rise_ev) begin
            if (lsb_first) begin
                shreg <= {rx_bit, shreg[7:1]};
            end else begin
                shreg <= {shreg[6:0], rx_bit};
            end
        end
    end

    // serial output bit, updated on falling edge
    logic tx_lvl;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_lvl <= 1'b1;
        end else if (fall_ev) begin
            tx_lvl <= lsb_first ? shreg[0] : shreg[7];
        end
    end

    // ==========================================================
    // pin drives, registered
    logic data_oe_next;
    assign data_oe_next = mode_q.tx_en && !(bus_mode && mode_q.wakeup);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_out <= 1'b1;
            sck_oe <= 1'b0;
            pin_a_out <= 1'b1;
            pin_a_oe <= 1'b0;
            pin_b_out <= 1'b1;
            pin_b_oe <= 1'b0;
        end else begin
            sck_out <= sck_lvl;
            sck_oe <= internal_clk;
            if (bus_mode) begin
                // open drain: drive low only
                pin_a_out <= 1'b0;
                pin_b_out <= 1'b0;
                pin_a_oe <= data_oe_next && !mode_q.pin_sel && !tx_lvl;
                pin_b_oe <= data_oe_next && mode_q.pin_sel && !tx_lvl;
            end else begin
                pin_a_out <= tx_lvl;
                pin_a_oe <= data_oe_next;
                pin_b_out <= 1'b1;
                pin_b_oe <= 1'b0;
            end
        end
    end

    // ==========================================================
    // completion request and read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            transfer_done_irq <= 1'b0;
        end else begin
            transfer_done_irq <= last_rise && !mode_q.wakeup;
        end
    end

    // read data stand one cycle after the strobe and are zero otherwise
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                CSP_ADDR_MODE: rdata <= mode_q;
                CSP_ADDR_SHIFT: rdata <= shreg;
                CSP_ADDR_BAUD: rdata <= baud_q;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ==========================================================
    // assertions
    property p_irq_pulse;
        @(posedge ref_clk) disable iff (rst)
        transfer_done_irq |=> !transfer_done_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

    property p_irq_cause;
        @(posedge ref_clk) disable iff (rst)
        transfer_done_irq |-> $past(last_rise) && !$past(mode_q.wakeup);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without eighth edge");

    property p_idle_clk_high;
        @(posedge ref_clk) disable iff (rst)
        !busy |=> sck_lvl;
    endproperty
    a_idle_clk_high: assert property (p_idle_clk_high) else $error("clock low when idle");

    property p_txoff_float;
        @(posedge ref_clk) disable iff (rst)
        !mode_q.tx_en |=> !pin_a_oe && !pin_b_oe;
    endproperty
    a_txoff_float: assert property (p_txoff_float) else $error("data driven while off");

    property p_no_shift_idle;
        @(posedge ref_clk) disable iff (rst)
        !busy && !wr_shift |=> $stable(shreg);
    endproperty
    a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while idle");

    property p_rx_dup;
        @(posedge ref_clk) disable iff (rst)
        (wr_mode && mode_q.rx_en && !mode_q.tx_en && !busy && !wr_shift && !rd_shift)
            |=> !busy;
    endproperty
    a_rx_dup: assert property (p_rx_dup) else $error("start on repeated enable");

    property p_rx_tx_block;
        @(posedge ref_clk) disable iff (rst)
        (wr_mode && new_tx_en && !busy && !wr_shift) |=> !busy;
    endproperty
    a_rx_tx_block: assert property (p_rx_tx_block) else $error("start with tx enabled");

    property p_tx_start;
        @(posedge ref_clk) disable iff (rst)
        (wr_shift && mode_q.tx_en && !busy) |=> busy;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("write did not start");

    property p_cnt_clear;
        @(posedge ref_clk) disable iff (rst)
        both_off |=> bit_cnt == 4'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

    property p_rx_zero;
        @(posedge ref_clk) disable iff (rst)
        (rise_ev && !mode_q.rx_en && !lsb_first && !wr_shift) |=> shreg[0] == 1'b0;
    endproperty
    a_rx_zero: assert property (p_rx_zero) else $error("nonzero bit with rx off");

    // a frame closes in the cycle after its eighth rise, clock parked high
    sequence s_eighth_rise;
        last_rise;
    endsequence
    sequence s_frame_closed;
        !busy && sck_lvl;
    endsequence
    property p_frame_end;
        @(posedge ref_clk) disable iff (rst)
        s_eighth_rise |=> s_frame_closed;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not closed");

    property p_read_shift;
        @(posedge ref_clk) disable iff (rst)
        rd_shift |=> rdata == $past(shreg);
    endproperty
    a_read_shift: assert property (p_read_shift) else $error("shift read data wrong");

    property p_clk_drive;
        @(posedge ref_clk) disable iff (rst)
        busy && internal_clk |=> sck_oe;
    endproperty
    a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");
endmodule : csp_port

// [tb/csp_peer.sv]
`timescale 1ns/1ps
// ==========================================================
// far-side serial peripheral: presents a byte, captures a byte
module csp_peer (
    input wire logic sck,          // serial clock wire level
    input wire logic sdi,          // data from the port (pin a wire)
    input wire logic load,         // rising edge arms a new frame
    input wire logic lsb,          // bit order of this frame
    input wire logic [7:0] tx_byte, // byte presented to the port
    output logic sdo,              // data toward the port (pin b)
    output logic [7:0] rx_byte     // byte captured from the port
);
    int idx; // rising edges seen in this frame
    initial begin
        idx = 8;
        sdo = 1'b1;
        rx_byte = 8'h00;
    end
    // arm: first bit valid before the first falling edge
    always @(posedge load) begin
        idx = 0;
        rx_byte = 8'h00;
        sdo = lsb ? tx_byte[0] : tx_byte[7];
    end
    // capture on rising edge, bit held steady across it
    always @(posedge sck) begin
        if (idx < 8) begin
            rx_byte[lsb ? idx : 7 - idx] = sdi;
            idx++;
        end
    end
    // next bit on falling edge; past the frame the line toggles
    always @(negedge sck) begin
        if (idx < 8) sdo = lsb ? tx_byte[idx] : tx_byte[7 - idx];
        else sdo = ~sdo;
    end
endmodule : csp_peer

// [tb/tb_clocked_serial_three_wire_port.sv]
`timescale 1ns/1ps
// ==========================================================
// bench: register tasks, frame runs, external clock runs
module tb_clocked_serial_three_wire_port;
    import csp_pkg::*;
    logic ref_clk, rst, ext_sck, peer_ld, peer_lsb, peer_sdo;
    logic [7:0] peer_byte, peer_rx, rdata;
    logic sck_out, sck_oe, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq;
    logic sck_w, pin_a_w, pin_b_w;
    csp_req_t req;
    int mismatches, comparisons, irq_cnt, cyc, seed;
    logic [7:0] modes [8] = '{8'hc3, 8'hc6, 8'hd1, 8'h83, 8'h43, 8'h47, 8'ha3, 8'h8b};
    logic [7:0] rx_model [$]; // bytes armed into the peer, oldest first
    // wire levels from all drivers; pin a pulled high when floating
    assign sck_w = sck_oe ? sck_out : ext_sck;
    assign pin_a_w = pin_a_oe ? pin_a_out : 1'b1;
    assign pin_b_w = pin_b_oe ? pin_b_out : peer_sdo;
    csp_port DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .pin_a_in(pin_a_w),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b_w),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .transfer_done_irq(irq));
    csp_peer peer (.sck(sck_w), .sdi(pin_a_w), .load(peer_ld), .lsb(peer_lsb),
        .tx_byte(peer_byte), .sdo(peer_sdo), .rx_byte(peer_rx));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // count done pulses and cut a hang short
    always @(posedge ref_clk) begin
        if (irq === 1'b1) irq_cnt++;
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // arm the peer with a random byte, returned for the model
    task automatic arm(input logic lsb, output logic [7:0] b);
        b = 8'($random(seed));
        rx_model.push_back(b);
        @(posedge ref_clk);
        peer_byte <= b;
        peer_lsb <= lsb;
        peer_ld <= 1'b1;
        @(posedge ref_clk);
        peer_ld <= 1'b0;
    endtask : arm
    task automatic wait_irq(input int n0);
        for (int i = 0; i < 700 && irq_cnt == n0; i++) @(posedge ref_clk);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk); // look at outputs away from the launching edge
    endtask : wait_irq
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk) ext_sck <= 1'b0;
            repeat (4) @(posedge ref_clk);
            ext_sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        @(negedge ref_clk); // outputs settled before any look
    endtask : pulses
    // one frame in mode m, checked against the bench model
    task automatic xfer(input logic [7:0] m);
        int n0;
        logic [7:0] d, q, pb, pb2;
        logic lsb;
        d = 8'($random(seed));
        rx_model.delete();
        lsb = (m[3:2] == CSP_MODE_LSB);
        arm(lsb, pb);
        wr(CSP_ADDR_MODE, 8'h00);
        n0 = irq_cnt;
        wr(CSP_ADDR_MODE, m);
        rd(CSP_ADDR_MODE, q);
        check(q, m);
        if (m[7]) begin
            repeat (100) @(posedge ref_clk);
            check(8'(irq_cnt - n0), 8'h00);
            wr(CSP_ADDR_SHIFT, d);
        end
        wait_irq(n0);
        check(8'(irq_cnt - n0), {7'h0, !m[5]});
        check({7'h0, sck_out}, 8'h01);
        check({7'h0, sck_oe}, 8'h01);
        if (!m[5] && m[3:2] != CSP_MODE_BUS) check({7'h0, pin_a_oe}, {7'h0, m[7]});
        if (m[3:2] == CSP_MODE_BUS) check({6'h0, pin_a_out, pin_b_out}, 8'h00);
        check({7'h0, pin_b_oe}, 8'h00);
        if (m[7] && !m[5]) check(peer_rx, d);
        if (m[6]) begin
            arm(lsb, pb2);
            n0 = irq_cnt;
            rd(CSP_ADDR_SHIFT, q);
            check(q, rx_model.pop_front());
            wait_irq(n0);
            // a read restarts reception only while transmit is off
            check(8'(irq_cnt - n0), {7'h0, !m[7]});
            if (!m[7]) begin
                n0 = irq_cnt;
                wr(CSP_ADDR_MODE, m);
                repeat (300) @(posedge ref_clk);
                check(8'(irq_cnt - n0), 8'h00);
            end
        end else begin
            rd(CSP_ADDR_SHIFT, q);
            check(q, 8'h00);
        end
    endtask : xfer
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        logic [7:0] q, d, pb;
        logic a0;
        int n0;
        seed = 43950;
        rst = 1'b1;
        ext_sck = 1'b1;
        peer_ld = 1'b0;
        peer_lsb = 1'b0;
        peer_byte = 8'h00;
        req = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(CSP_ADDR_MODE, q);
        check(q, CSP_MODE_RESET);
        rd(16'hff90, q);
        check(q, 8'h00);
        rd(CSP_ADDR_BAUD, q);
        check(q, CSP_BAUD_RESET);
        wr(CSP_ADDR_BAUD, 8'h02);
        foreach (modes[i]) xfer(modes[i]);
        // external clock: idle pulses, aborted frame, clean frame
        d = 8'($random(seed));
        wr(CSP_ADDR_MODE, 8'h00);
        wr(CSP_ADDR_MODE, 8'h80);
        @(negedge ref_clk);
        check({7'h0, sck_oe}, 8'h00);
        a0 = pin_a_out;
        n0 = irq_cnt;
        pulses(4);
        check({7'h0, pin_a_out}, {7'h0, a0});
        check(8'(irq_cnt - n0), 8'h00);
        wr(CSP_ADDR_SHIFT, d);
        pulses(3);
        wr(CSP_ADDR_MODE, 8'h00);
        wr(CSP_ADDR_MODE, 8'h80);
        arm(1'b0, pb);
        wr(CSP_ADDR_SHIFT, d);
        n0 = irq_cnt;
        pulses(8);
        check(8'(irq_cnt - n0), 8'h01);
        check(peer_rx, d);
        stop_test();
    end
endmodule : tb_clocked_serial_three_wire_port
